// file: host_port_memory_access_bench.sv
// Self-checking bench of the host port memory access block
`timescale 1ns/1ps
`include "hpm_map.vh"
module host_port_memory_access_bench;
  reg hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, core_req = 1'h0;
  reg idle_level_one = 1'h0, idle_level_two = 1'h0, port_enable_input = 1'h1;
  reg wide_mode_select = 1'h0, dma_ack = 1'h0;
  reg [31:0] haddr = 32'h0, hwdata = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg [2:0] hsize = 3'h2;
  reg [15:0] core_addr = 16'h0, dma_rdata = 16'h0;
  reg [15:0] mem [0:255]; // Internal memory behind the DMA bus
  reg seen_hold = 1'h0, seen_clk = 1'h0, seen_cint = 1'h0; // Sticky event flags
  wire hready, hreadyout, hresp, host_wide_data_oe_n, host_ready_out, host_int_n;
  wire core_int, core_hold, clk_req, data_keeper_on, addr_keeper_on, byte_keeper_on;
  wire dma_req, dma_we, data_strobe_one_n, data_strobe_two_n, host_chip_select_n;
  wire host_read_write, byte_half_select;
  wire [1:0] host_access_select;
  wire [31:0] hrdata;
  wire [7:0] host_byte_bus_in, host_byte_bus_out, host_byte_bus_oe_n;
  wire [15:0] host_wide_data_in, host_wide_data_out, host_address_pins, dma_addr, dma_wdata;
  integer n_fail = 0, check_count = 0, lat = 0, wt = 0, dma_n = 0, n, i;
  assign hready = hreadyout; // Single slave drives the bus ready
  hpm_top hpm_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hrdata, .hresp, .host_byte_bus_in, .host_byte_bus_out,
    .host_byte_bus_oe_n, .host_wide_data_in, .host_wide_data_out, .host_wide_data_oe_n,
    .host_address_pins, .data_strobe_one_n, .data_strobe_two_n, .host_chip_select_n,
    .host_read_write, .byte_half_select, .host_access_select, .port_enable_input,
    .wide_mode_select, .host_ready_out, .host_int_n, .core_int, .core_req, .core_addr,
    .core_hold, .idle_level_one, .idle_level_two, .clk_req, .data_keeper_on,
    .addr_keeper_on, .byte_keeper_on, .dma_req, .dma_we, .dma_addr, .dma_wdata,
    .dma_rdata, .dma_ack);
  hpm_host_model hpm_host_model_i (.hclk, .host_byte_bus_out, .host_byte_bus_oe_n,
    .host_wide_data_out, .host_wide_data_oe_n, .host_ready_out, .host_byte_bus_in,
    .host_wide_data_in, .host_address_pins, .data_strobe_one_n, .data_strobe_two_n,
    .host_chip_select_n, .host_read_write, .byte_half_select, .host_access_select);
  initial forever #2 hclk = ~hclk;
  // Memory answers after lat cycles; read data is scrambled outside the ack cycle
  always @(posedge hclk) begin
    dma_ack <= 1'h0;
    dma_rdata <= ~dma_rdata;
    if (core_hold) seen_hold <= 1'h1;
    if (clk_req) seen_clk <= 1'h1;
    if (core_int) seen_cint <= 1'h1;
    if (dma_req && !dma_ack) begin
      wt <= wt + 1;
      if (wt >= lat) begin
        dma_ack <= 1'h1;
        wt <= 0;
        dma_n <= dma_n + 1;
        dma_rdata <= mem[dma_addr[7:0]];
        if (dma_we) mem[dma_addr[7:0]] <= dma_wdata;
      end
    end
  end
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Wait for ready at a rising edge, bounded
  task wait_hr;
    integer k;
    begin
      k = 0;
      @(posedge hclk);
      while (!hreadyout && k < 50) begin
        @(posedge hclk);
        k = k + 1;
      end
      if (!hreadyout) begin
        n_fail = n_fail + 1;
        tally_and_finish;
      end
    end
  endtask
  // One single word transfer; x is the register index
  task ahb(input w, input [9:0] x, input [31:0] d, output [31:0] q);
    begin
      hsel <= 1'h1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {20'h0, x, 2'h0};
      wait_hr;
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_hr;
      q = hrdata;
      repeat (2) @(posedge hclk);
    end
  endtask
  task aw(input [9:0] x, input [31:0] d);
    reg [31:0] q;
    ahb(1'h1, x, d, q);
  endtask
  task ar(input [9:0] x, input [31:0] e);
    reg [31:0] q;
    begin
      ahb(1'h0, x, 32'h0, q);
      chk(q, e);
      chk(hresp, 32'h0);
    end
  endtask
  // Host access through the partner; e is the expected read value
  task hp(input r, input [1:0] s, input b, input [15:0] a, input [15:0] d, input [15:0] e);
    reg [15:0] q;
    reg ok;
    begin
      hpm_host_model_i.access(r, s, b, a, d, q, ok);
      chk(ok, 1'h1);
      if (!ok) tally_and_finish;
      if (r) chk(q, e);
    end
  endtask
  // Strap is set while reset is low, host waits past the strap latch
  task rst(input w);
    begin
      wide_mode_select <= w;
      hresetn <= 1'h0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'h1;
      repeat (6) @(posedge hclk);
    end
  endtask
  initial begin
    for (i = 0; i < 256; i = i + 1) mem[i] = i[15:0];
    rst(1'h0);
    ar(`HPM_IDX_BANK, 32'hf800);
    chk(byte_keeper_on, 1'h0);
    aw(`HPM_IDX_BANK, 32'hffffffff);
    ar(`HPM_IDX_BANK, 32'hf807);
    chk({data_keeper_on, addr_keeper_on, byte_keeper_on}, 3'h5);
    aw(10'h100, 32'h1);
    ar(10'h100, 32'h0);
    $display("test registers done");
    hp(1'h0, `HPM_SEL_ADDR, 1'h0, 16'h0, 16'h00, 16'h0);
    hp(1'h0, `HPM_SEL_ADDR, 1'h1, 16'h0, 16'h10, 16'h0);
    hp(1'h0, `HPM_SEL_DATA_INC, 1'h0, 16'h0, 16'hab, 16'h0);
    hp(1'h0, `HPM_SEL_DATA_INC, 1'h1, 16'h0, 16'hcd, 16'h0);
    lat = 5;
    hp(1'h0, `HPM_SEL_DATA_INC, 1'h0, 16'h0, 16'h12, 16'h0);
    hp(1'h0, `HPM_SEL_DATA_INC, 1'h1, 16'h0, 16'h34, 16'h0);
    chk(mem[16], 16'habcd);
    chk(mem[17], 16'h1234);
    hp(1'h0, `HPM_SEL_ADDR, 1'h0, 16'h0, 16'h00, 16'h0);
    hp(1'h0, `HPM_SEL_ADDR, 1'h1, 16'h0, 16'h11, 16'h0);
    core_req <= 1'h1;
    core_addr <= 16'h11;
    idle_level_one <= 1'h1;
    hp(1'h1, `HPM_SEL_DATA, 1'h0, 16'h0, 16'h0, 16'h12);
    hp(1'h1, `HPM_SEL_DATA, 1'h1, 16'h0, 16'h0, 16'h34);
    core_req <= 1'h0;
    idle_level_one <= 1'h0;
    chk(seen_hold, 1'h1);
    chk(seen_clk, 1'h1);
    hp(1'h1, `HPM_SEL_ADDR, 1'h1, 16'h0, 16'h0, 16'h11);
    $display("test byte transfers done");
    aw(`HPM_IDX_CTRL, 32'h4);
    chk(host_int_n, 1'h0);
    hp(1'h0, `HPM_SEL_CTRL, 1'h0, 16'h0, 16'h0, 16'h0);
    hp(1'h0, `HPM_SEL_CTRL, 1'h1, 16'h0, 16'h6, 16'h0);
    chk(host_int_n, 1'h1);
    chk(seen_cint, 1'h1);
    hp(1'h1, `HPM_SEL_CTRL, 1'h1, 16'h0, 16'h0, 16'h2);
    ar(`HPM_IDX_CTRL, 32'h2);
    aw(`HPM_IDX_CTRL, 32'h2);
    ar(`HPM_IDX_CTRL, 32'h0);
    $display("test interrupts done");
    rst(1'h1);
    chk({addr_keeper_on, byte_keeper_on}, 2'h1);
    aw(`HPM_IDX_BANK, 32'h4);
    chk({addr_keeper_on, byte_keeper_on}, 2'h3);
    hp(1'h0, 2'h0, 1'h0, 16'h20, 16'h5678, 16'h0);
    chk(mem[32], 16'h5678);
    hp(1'h1, 2'h0, 1'h0, 16'h20, 16'h0, 16'h5678);
    n = dma_n;
    hp(1'h0, 2'h0, 1'h0, 16'h8000, 16'hdead, 16'h0);
    hp(1'h1, 2'h0, 1'h0, 16'h8000, 16'h0, 16'h0);
    chk(dma_n - n, 32'h0);
    aw(`HPM_IDX_GPIO_DIR, 32'hff);
    aw(`HPM_IDX_GPIO_OUT, 32'h5a);
    chk({host_byte_bus_oe_n, host_byte_bus_out}, 16'h005a);
    $display("test wide mode done");
    tally_and_finish;
  end
endmodule // host_port_memory_access_bench

// file: hpm_host_model.sv
// Host processor model on the parallel host pins
`timescale 1ns/1ps
module hpm_host_model (
  input wire hclk,
  input wire [7:0] host_byte_bus_out,
  input wire [7:0] host_byte_bus_oe_n,
  input wire [15:0] host_wide_data_out,
  input wire host_wide_data_oe_n,
  input wire host_ready_out,
  output wire [7:0] host_byte_bus_in,
  output wire [15:0] host_wide_data_in,
  output reg [15:0] host_address_pins = 16'h0,
  output reg data_strobe_one_n = 1'h1,
  output reg data_strobe_two_n = 1'h1,
  output reg host_chip_select_n = 1'h1,
  output reg host_read_write = 1'h1,
  output reg byte_half_select = 1'h0,
  output reg [1:0] host_access_select = 2'h0
);
  reg [15:0] val = 16'h0; // Host drive value
  reg drv = 1'h0; // Host drives data during writes
  integer i;
  // No pulls here: an undriven line shows the inverse of the last value
  assign host_byte_bus_in = ~host_byte_bus_oe_n & host_byte_bus_out |
    host_byte_bus_oe_n & (drv ? val[7:0] : ~host_byte_bus_out);
  assign host_wide_data_in = !host_wide_data_oe_n ? host_wide_data_out :
    drv ? val : ~host_wide_data_out;
  // One host access; ok stays low when ready never returns
  task access(input r, input [1:0] s, input b, input [15:0] a, input [15:0] d,
      output [15:0] q, output ok);
    begin
      @(posedge hclk);
      host_read_write <= r;
      host_access_select <= s;
      byte_half_select <= b;
      host_address_pins <= a;
      val <= d;
      drv <= !r;
      @(posedge hclk);
      data_strobe_one_n <= 1'h0;
      host_chip_select_n <= 1'h0;
      // Ready falls a few cycles after the strobe, sampled mid-cycle
      for (i = 0; i < 20 && host_ready_out; i = i + 1) @(negedge hclk);
      // An access that never drops ready was not taken at all
      ok = !host_ready_out;
      for (i = 0; i < 300 && !host_ready_out; i = i + 1) @(negedge hclk);
      ok = ok && host_ready_out;
      q = host_wide_data_oe_n ? {8'h00, host_byte_bus_in} : host_wide_data_in;
      @(posedge hclk);
      data_strobe_one_n <= 1'h1;
      host_chip_select_n <= 1'h1;
      drv <= 1'h0;
      // Strobe stays off long enough for the port to return to idle
      repeat (5) @(posedge hclk);
    end
  endtask
endmodule // hpm_host_model

// file: hpm_map.vh
// Constants of the host port memory access block
// How it works
// - Host is slave master of whole on-chip RAM
// - Addresses beyond on-chip RAM are never accessed
// - Host wins contention, core held when it requests the address of a pending DMA cycle
// - 8-bit mode moves words as byte pairs
// - Address, data, control registers in 8-bit mode
// - Disabled or wide mode frees byte pins
// - Wide mode uses separate data and address buses
// - Wide mode stalls host via ready output
// - Control register unreachable in wide mode
// - Every wide on-chip access becomes DMA cycle
// - No interrupts either way in wide mode
// - 8-bit mode interrupts both directions
// - Auto-increment and random address transfers
// - Wide select latched at reset, held stable
// - Bank switch bits one and two control keepers
// - 8-bit mode byte keepers follow host bit
// - Wide mode byte keepers on, bit gates address
// - Idle levels request clocks per access
// - Host accesses never wake the idle core
// - Transfers continue during emulation stop
// - Host keeper bit clears at reset
// - Enabled keeper holds last driven level
`ifndef HPM_MAP_VH
`define HPM_MAP_VH

// Register indices; byte address is four times the index
`define HPM_IDX_BANK 10'h029
`define HPM_IDX_CTRL 10'h02c
`define HPM_IDX_GPIO_OUT 10'h02d
`define HPM_IDX_GPIO_DIR 10'h02e
`define HPM_IDX_STATUS 10'h02f

// Bank switch control fields and reset value
`define HPM_BANK_RESET 16'hf800
`define HPM_BANK_WMASK 16'hf807
`define HPM_BANK_DKEEP 1
`define HPM_BANK_HKEEP 2

// Control register fields
`define HPM_CTRL_DSPINT 1
`define HPM_CTRL_HINT 2

// Host access select codes in 8-bit mode
`define HPM_SEL_CTRL 2'h0
`define HPM_SEL_DATA_INC 2'h1
`define HPM_SEL_ADDR 2'h2
`define HPM_SEL_DATA 2'h3

// Last word address of on-chip RAM
`define HPM_ONCHIP_TOP 16'h7fff

// Width of the synchronised pin bundle
`define HPM_SYNC_W 49

`endif

// file: hpm_sync.v
// Two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module hpm_sync #(
  parameter W = 1
) (
  input wire hclk,
  input wire hresetn,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

  reg [W-1:0] meta; // First stage, read only by the second

  // Both stages reset to zero; strobes are decoded with polarity in mind
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule // hpm_sync

// file: hpm_top.v
// Host port memory access: host pins, DMA master and AHB-Lite registers
`timescale 1ns/1ps
`include "hpm_map.vh"
module hpm_top (
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg [31:0] hrdata,
  output reg hresp,
  // Host pins
  input wire [7:0] host_byte_bus_in,
  output reg [7:0] host_byte_bus_out,
  output reg [7:0] host_byte_bus_oe_n,
  input wire [15:0] host_wide_data_in,
  output reg [15:0] host_wide_data_out,
  output reg host_wide_data_oe_n,
  input wire [15:0] host_address_pins,
  input wire data_strobe_one_n,
  input wire data_strobe_two_n,
  input wire host_chip_select_n,
  input wire host_read_write,
  input wire byte_half_select,
  input wire [1:0] host_access_select,
  input wire port_enable_input,
  input wire wide_mode_select,
  output reg host_ready_out,
  output reg host_int_n,
  // Core side
  output reg core_int,
  input wire core_req,
  input wire [15:0] core_addr,
  output reg core_hold,
  input wire idle_level_one,
  input wire idle_level_two,
  output reg clk_req,
  // Keeper enables
  output reg data_keeper_on,
  output reg addr_keeper_on,
  output reg byte_keeper_on,
  // Internal DMA bus master
  output reg dma_req,
  output reg dma_we,
  output reg [15:0] dma_addr,
  output reg [15:0] dma_wdata,
  input wire [15:0] dma_rdata,
  input wire dma_ack
);

  // Access states
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_DONE = 2'h2;

  wire [`HPM_SYNC_W-1:0] pins_sync; // Synchronised pins
  wire [7:0] s_byte; // Byte bus as sampled
  wire [15:0] s_wdata; // Wide data bus as sampled
  wire [15:0] s_addr; // Address pins as sampled
  wire s_ds1, s_ds2, s_cs, s_rw, s_half, s_en, s_wide;
  wire [1:0] s_sel;
  wire strobe; // Host strobe active
  wire start; // New host access this cycle
  wire port_on; // Port carries host accesses
  wire gpio_mode; // Byte pins are general purpose

  reg [1:0] state; // Access state
  reg strobe_prev; // Strobe one cycle ago
  reg [1:0] strap_cnt; // Cycles since reset release
  reg wide; // Latched wide mode
  reg [15:0] host_addr_reg; // Address register
  reg [15:0] host_data_reg; // Data register, last word read from memory
  reg [7:0] wr_hi; // First byte of a byte-pair write
  reg acc_rd; // Current access reads
  reg acc_inc; // Current access increments address
  reg dspint_flag; // Host-to-core request, sticky
  reg hint; // Core-to-host request
  reg [15:0] bank_switch_ctrl_reg; // Bank switch control
  reg [7:0] gpio_out; // Byte pins as outputs
  reg [7:0] gpio_dir; // Byte pin direction, 1 drives
  reg [7:0] drive_byte; // Byte presented on a host read
  reg ahb_wr; // Write data phase pending
  reg [9:0] ahb_idx; // Captured register index
  reg next_hint; // Next core-to-host request
  reg next_dspint; // Next host-to-core flag
  reg host_clr_hint; // Host clears core-to-host request
  reg host_set_dspint; // Host raises core request
  reg core_set_hint; // Core raises host request
  reg core_clr_dspint; // Core clears its flag

  // Every host pin is resynchronised before use
  hpm_sync #(
    .W(`HPM_SYNC_W)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({host_byte_bus_in, host_wide_data_in, host_address_pins, data_strobe_one_n,
        data_strobe_two_n, host_chip_select_n, host_read_write, byte_half_select,
        host_access_select, port_enable_input, wide_mode_select}),
    .q(pins_sync)
  );

  assign s_byte = pins_sync[48:41];
  assign s_wdata = pins_sync[40:25];
  assign s_addr = pins_sync[24:9];
  assign s_ds1 = pins_sync[8];
  assign s_ds2 = pins_sync[7];
  assign s_cs = pins_sync[6];
  assign s_rw = pins_sync[5];
  assign s_half = pins_sync[4];
  assign s_sel = pins_sync[3:2];
  assign s_en = pins_sync[1];
  assign s_wide = pins_sync[0];

  // Strobe is the exclusive-or of the data strobes, qualified by chip select
  assign strobe = !s_cs && (s_ds1 ^ s_ds2);
  assign port_on = s_en && (strap_cnt == 2'h3);
  assign start = strobe && !strobe_prev && (state == ST_IDLE) && port_on;
  assign gpio_mode = !s_en || wide;

  // Catch the wide mode strap once the synchroniser has settled after reset
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_cnt <= 2'h0;
      wide <= 1'b0;
    end else if (strap_cnt != 2'h3) begin
      strap_cnt <= strap_cnt + 2'h1;
      wide <= s_wide;
    end
  end

  // Interrupt flag updates; a set in the same cycle as a clear wins
  always @* begin
    host_clr_hint = 1'b0;
    host_set_dspint = 1'b0;
    if (start && !wide && !s_rw && (s_sel == `HPM_SEL_CTRL) && s_half) begin
      host_clr_hint = s_byte[`HPM_CTRL_HINT];
      host_set_dspint = s_byte[`HPM_CTRL_DSPINT];
    end
    core_set_hint = ahb_wr && (ahb_idx == `HPM_IDX_CTRL) && hwdata[`HPM_CTRL_HINT] && !wide;
    core_clr_dspint = ahb_wr && (ahb_idx == `HPM_IDX_CTRL) && hwdata[`HPM_CTRL_DSPINT];
    next_hint = core_set_hint || (hint && !host_clr_hint);
    next_dspint = host_set_dspint || (dspint_flag && !core_clr_dspint);
  end

  // Host access sequencer with the DMA master behind it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
      strobe_prev <= 1'b0;
      host_addr_reg <= 16'h0000;
      host_data_reg <= 16'h0000;
      wr_hi <= 8'h00;
      acc_rd <= 1'b0;
      acc_inc <= 1'b0;
      drive_byte <= 8'h00;
      dma_req <= 1'b0;
      dma_we <= 1'b0;
      dma_addr <= 16'h0000;
      dma_wdata <= 16'h0000;
      host_ready_out <= 1'b1;
      core_hold <= 1'b0;
      clk_req <= 1'b0;
    end else begin
      strobe_prev <= strobe;
      // Core is held only while a host cycle hits its address
      core_hold <= dma_req && core_req && (core_addr == dma_addr);
      // Clocks are requested per access in idle, the core is never woken
      clk_req <= (idle_level_one || idle_level_two) && (start || state != ST_IDLE);
      case (state)
        ST_IDLE: begin
          host_ready_out <= 1'b1;
          if (start) begin
            host_ready_out <= 1'b0;
            acc_rd <= s_rw;
            state <= ST_DONE;
            if (wide) begin
              // Wide mode: address from pins, every on-chip access is a DMA cycle
              host_addr_reg <= s_addr;
              acc_inc <= 1'b0;
              if (s_addr <= `HPM_ONCHIP_TOP) begin
                dma_req <= 1'b1;
                dma_we <= !s_rw;
                dma_addr <= s_addr;
                dma_wdata <= s_wdata;
                state <= ST_RUN;
              end else begin
                host_data_reg <= 16'h0000;
              end
            end else begin
              acc_inc <= (s_sel == `HPM_SEL_DATA_INC);
              case (s_sel)
                `HPM_SEL_CTRL: begin
                  drive_byte <= {5'h00, hint, dspint_flag, 1'b0};
                end
                `HPM_SEL_ADDR: begin
                  drive_byte <= s_half ? host_addr_reg[7:0] : host_addr_reg[15:8];
                  if (!s_rw && s_half) begin
                    host_addr_reg[7:0] <= s_byte;
                  end else if (!s_rw) begin
                    host_addr_reg[15:8] <= s_byte;
                  end
                end
                default: begin
                  // Data: first byte is high, second byte low
                  if (s_rw && s_half) begin
                    drive_byte <= host_data_reg[7:0];
                  end else if (!s_rw && !s_half) begin
                    wr_hi <= s_byte;
                  end else if (host_addr_reg <= `HPM_ONCHIP_TOP) begin
                    dma_req <= 1'b1;
                    dma_we <= !s_rw;
                    dma_addr <= host_addr_reg;
                    dma_wdata <= {wr_hi, s_byte};
                    state <= ST_RUN;
                  end else begin
                    host_data_reg <= 16'h0000;
                    drive_byte <= 8'h00;
                  end
                end
              endcase
            end
          end
        end
        ST_RUN: begin
          // Host keeps priority; the access runs even with the core stopped
          if (dma_ack) begin
            dma_req <= 1'b0;
            if (acc_rd) begin
              host_data_reg <= dma_rdata;
              drive_byte <= dma_rdata[15:8];
            end
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          // Ready rises only after the memory cycle is over
          host_ready_out <= 1'b1;
          if (!strobe) begin
            if (acc_inc && (!wide) && s_half) begin
              host_addr_reg <= host_addr_reg + 16'h0001;
            end
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Pin drivers; output data keeps its last level when released
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      host_byte_bus_out <= 8'h00;
      host_byte_bus_oe_n <= 8'hff;
      host_wide_data_out <= 16'h0000;
      host_wide_data_oe_n <= 1'b1;
    end else begin
      if (gpio_mode) begin
        host_byte_bus_out <= gpio_out;
        host_byte_bus_oe_n <= ~gpio_dir;
      end else if (state == ST_DONE && acc_rd && strobe) begin
        host_byte_bus_out <= drive_byte;
        host_byte_bus_oe_n <= 8'h00;
      end else begin
        host_byte_bus_oe_n <= 8'hff;
      end
      if (wide && state == ST_DONE && acc_rd && strobe) begin
        host_wide_data_out <= host_data_reg;
        host_wide_data_oe_n <= 1'b0;
      end else begin
        host_wide_data_oe_n <= 1'b1;
      end
    end
  end

  // Interrupts both ways in byte mode only
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hint <= 1'b0;
      dspint_flag <= 1'b0;
      core_int <= 1'b0;
      host_int_n <= 1'b1;
    end else begin
      hint <= next_hint && !wide;
      dspint_flag <= next_dspint && !wide;
      core_int <= host_set_dspint && !wide;
      host_int_n <= !(next_hint && !wide);
    end
  end

  // Keeper enables from the bank switch bits and the wide strap
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_keeper_on <= 1'b0;
      addr_keeper_on <= 1'b0;
      byte_keeper_on <= 1'b0;
    end else begin
      data_keeper_on <= bank_switch_ctrl_reg[`HPM_BANK_DKEEP];
      byte_keeper_on <= wide || bank_switch_ctrl_reg[`HPM_BANK_HKEEP];
      addr_keeper_on <= wide && bank_switch_ctrl_reg[`HPM_BANK_HKEEP];
    end
  end

  // AHB-Lite slave: zero wait states, read data set up at the address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      ahb_wr <= 1'b0;
      ahb_idx <= 10'h000;
      bank_switch_ctrl_reg <= `HPM_BANK_RESET;
      gpio_out <= 8'h00;
      gpio_dir <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ahb_wr <= 1'b0;
      // Data phase of a pending write
      if (ahb_wr) begin
        case (ahb_idx)
          `HPM_IDX_BANK: begin
            bank_switch_ctrl_reg <= (hwdata[15:0] & `HPM_BANK_WMASK) |
                                    (bank_switch_ctrl_reg & ~`HPM_BANK_WMASK);
          end
          `HPM_IDX_GPIO_OUT: begin
            gpio_out <= hwdata[7:0];
          end
          `HPM_IDX_GPIO_DIR: begin
            gpio_dir <= hwdata[7:0];
          end
          default: begin
            // Control handled with the flags, unmapped ignored
          end
        endcase
      end
      // Address phase
      if (hsel && htrans[1] && hready) begin
        ahb_idx <= haddr[11:2];
        ahb_wr <= hwrite;
        if (!hwrite) begin
          case (haddr[11:2])
            `HPM_IDX_BANK: hrdata <= {16'h0000, bank_switch_ctrl_reg};
            `HPM_IDX_CTRL: hrdata <= {29'h00000000, hint, dspint_flag, 1'b0};
            `HPM_IDX_GPIO_OUT: hrdata <= {24'h000000, gpio_out};
            `HPM_IDX_GPIO_DIR: hrdata <= {24'h000000, gpio_dir};
            `HPM_IDX_STATUS: hrdata <= {16'h0000, s_byte, 4'h0, (state != ST_IDLE), s_en,
                                        port_on, wide};
            default: hrdata <= 32'h00000000;
          endcase
        end
      end
    end
  end

endmodule // hpm_top

// file: hpm_top_assertions.sv
// Checker of host port timing and mode relations at the top ports
`timescale 1ns/1ps
module hpm_top_assertions (
  input wire hclk,
  input wire hresetn,
  input wire host_ready_out,
  input wire host_int_n,
  input wire core_int,
  input wire core_req,
  input wire [15:0] core_addr,
  input wire core_hold,
  input wire idle_level_one,
  input wire idle_level_two,
  input wire clk_req,
  input wire wide_mode_select,
  input wire host_wide_data_oe_n,
  input wire addr_keeper_on,
  input wire byte_keeper_on,
  input wire dma_req,
  input wire [15:0] dma_addr,
  input wire dma_ack
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // DMA cycle still waiting for memory
  sequence s_wait;
    dma_req && !dma_ack;
  endsequence
  // DMA cycle granted by memory
  sequence s_grant;
    dma_req && dma_ack;
  endsequence
  a_dma_req_holds: assert property (s_wait |=> dma_req && $stable(dma_addr))
    else $error("dma request changed before ack");
  a_dma_req_ends: assert property (s_grant |=> !dma_req)
    else $error("dma request stayed after ack");
  a_ready_stalls: assert property (dma_req |-> !host_ready_out)
    else $error("ready high during memory cycle");
  a_onchip_only: assert property (dma_req |-> dma_addr <= 16'h7fff)
    else $error("dma reached beyond on-chip memory");
  a_host_wins: assert property (core_req && dma_req && core_addr == dma_addr |=> core_hold)
    else $error("core not held on contention");
  a_wide_no_irq: assert property (wide_mode_select |-> host_int_n && !core_int)
    else $error("interrupt raised in wide mode");
  a_wide_bus_mode: assert property (!host_wide_data_oe_n |-> wide_mode_select)
    else $error("wide bus driven in byte mode");
  a_keeper_order: assert property (addr_keeper_on |-> byte_keeper_on)
    else $error("address keepers on without byte keepers");
  a_idle_clocks: assert property (clk_req |-> $past(idle_level_one || idle_level_two))
    else $error("clock request outside idle");
  a_core_irq_pulse: assert property (core_int |=> !core_int)
    else $error("core interrupt longer than one cycle");
endmodule // hpm_top_assertions

bind hpm_top hpm_top_assertions hpm_top_assertions_i (.hclk, .hresetn, .host_ready_out,
  .host_int_n, .core_int, .core_req, .core_addr, .core_hold, .idle_level_one,
  .idle_level_two, .clk_req, .wide_mode_select, .host_wide_data_oe_n, .addr_keeper_on,
  .byte_keeper_on, .dma_req, .dma_addr, .dma_ack);
